// *** tsi_pkg.sv ***
// package: constants and types for the connection output control block
// assumes: single 10 MHz clock domain, host port sampled synchronously
package tsi_pkg;
    localparam int CLOCK_MHZ        = 10;
    localparam int ADDR_W           = 15;
    localparam int DATA_W           = 16;
    localparam int STREAMS          = 32;
    localparam int CHANNELS         = 256;
    localparam int MEM_AW           = 13;
    localparam int OFFSETS          = 8;
    localparam int FIFO_DEPTH       = 4;
    // address decode
    localparam int SPACE_HI         = 14;
    localparam int SPACE_LO         = 13;
    localparam int REG_SEL_HI       = 12;
    localparam int REG_SEL_LO       = 9;
    localparam logic [1:0] SPACE_DATA = 2'h3;
    localparam logic [1:0] SPACE_CONN = 2'h2;
    localparam logic [1:0] SPACE_REGS = 2'h1;
    localparam logic [3:0] SEL_CONTROL = 4'h0;
    localparam logic [3:0] SEL_ALIGN   = 4'h1;
    localparam logic [3:0] SEL_OFFSET0 = 4'h2;
    // control register fields and reset value
    localparam logic [15:0] CONTROL_RESET = 16'h4000;
    localparam int CR_SOFT_RESET    = 15;
    localparam int CR_ENABLE_IND    = 14;
    localparam int CR_IND_POLARITY  = 13;
    localparam int CR_ALL_OUT_IND   = 12;
    localparam int CR_STANDBY       = 5;
    localparam int CR_RATE_HI       = 3;
    localparam logic [15:0] ALIGN_RESET  = 16'h0000;
    localparam logic [15:0] OFFSET_RESET = 16'h0000;
    localparam logic [3:0] RATE_16M     = 4'h3;
    // connection memory entry fields
    localparam int CM_SEL_HI        = 15;
    localparam int CM_SEL_LO        = 14;
    localparam int CM_LOOPBACK      = 13;
    // delay limits, in slots and frames
    localparam int VAR_SAME_FRAME_SLOTS = 3;
    localparam int VAR_16M_MIN_SLOTS    = 6;
    localparam int CONST_MIN_FRAMES     = 2;
    localparam int CONST_MAX_FRAMES     = 3;
    typedef enum logic [1:0] {
        DELAY_VARIABLE  = 2'h0,
        DELAY_CONSTANT  = 2'h1,
        DELAY_PROCESSOR = 2'h2,
        DELAY_HIGH_Z    = 2'h3
    } channel_delay_select_t;
    typedef enum logic [1:0] {
        IND_NONE,
        IND_LOWER,
        IND_ALL
    } ind_mode_t;
endpackage

// *** tsi_slot_if.sv ***
// interface: one serial output slot word between scheduler and fifo
// assumes: producer and consumer on the same clock
`timescale 1ns/1ns
interface tsi_slot_if #(parameter int W = 24);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface

// *** tsi_fifo.sv ***
// module: small synchronous fifo with valid/ready on both sides
// assumes: one clock, asynchronous active-low reset
`timescale 1ns/1ns
module tsi_fifo #(
    parameter int W     = 24,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic rstn,
    // write side
    tsi_slot_if.sink  inPort,
    // read side
    output logic [W-1:0] outData,
    output logic         outValid,
    input  wire logic    outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] store [DEPTH];
    logic [AW:0]  count;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    wire push = inPort.valid && inPort.ready;
    wire pop  = outValid && outReady;
    assign inPort.ready = (count != DEPTH[AW:0]);
    assign outValid     = (count != '0);
    assign outData      = store[rdPtr];
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            count <= '0;
            wrPtr <= '0;
            rdPtr <= '0;
        end
        else
        begin
            if (push)
                wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
            if (pop)
                rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
            count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
    always_ff @(posedge clock)
    begin
        if (push)
            store[wrPtr] <= inPort.data;
    end
endmodule

// *** tsi_connection_output_control.sv ***
// module: connection memory control, output drive and indication, host port
// assumes: host port synchronous to clock; one serial slot per slotStrobe
`timescale 1ns/1ns
// Overview of operation
// RQ1: pin or standby lets entry govern driver
// RQ2: code 10 sends entry low byte
// RQ3: per-entry variable, constant or processor choice
// RQ4: loopback bit feeds output into same input
// RQ5: host zeroes offsets, regular rate for loopback
// RQ6: enable indication halves available output streams
// RQ7: all-outputs indication overrides enable indication
// RQ8: pair two devices for 32 indicated streams
// RQ9: reset restores registers, all outputs high-z
// RQ10: connection memory not cleared on reset
// RQ11: host keeps drive pin low while programming
// RQ12: code 11 forces high-z; else pin/bit
// RQ13: variable delay, three slots same frame
// RQ14: 16M to 16M variable minimum six slots
// RQ15: constant delay two to three frames
// RQ16: control register exposes output active state; code keeps activeState internal, control read returns switch_control only
// RQ17: address 11 reads data memory
// RQ18: address 10 connection memory, 01 registers
// RQ19: upper pins show lower streams' drive state
// RQ20: polarity bit selects indicator meaning
// RQ21: register decode ignores address bits 8..0
module tsi_connection_output_control
    import tsi_pkg::*;
#(
    parameter int STREAM_W  = 5,
    parameter int CHANNEL_W = 8
) (
    // clock and reset
    input  wire logic                       clock,
    input  wire logic                       rstn,
    // host port
    input  wire logic [tsi_pkg::ADDR_W-1:0] hostAddr,
    input  wire logic [tsi_pkg::DATA_W-1:0] hostWrData,
    input  wire logic                       hostWrite,
    input  wire logic                       hostRead,
    output logic [tsi_pkg::DATA_W-1:0]      hostRdData,
    // frame timing and switched data
    input  wire logic                       slotStrobe,
    input  wire logic [STREAM_W-1:0]        slotStream,
    input  wire logic [CHANNEL_W-1:0]       slotChannel,
    input  wire logic [7:0]                 switchedData,
    input  wire logic [7:0]                 rxData,
    input  wire logic [11:0]                alignResult,
    input  wire logic                       alignDone,
    // pins
    input  wire logic                       output_drive_enable_pin,
    output logic [tsi_pkg::STREAMS-1:0]     txOut,
    output logic [tsi_pkg::STREAMS-1:0]     txOe,
    // data path towards the switch core
    output logic [7:0]                      txByte,
    output logic [tsi_pkg::MEM_AW-1:0]      txSlot,
    output logic                            txValid,
    output logic [1:0]                      txDelayMode,
    output logic [7:0]                      loopbackByte,
    output logic                            loopbackValid,
    output logic                            softReset
);
    import tsi_pkg::*;
    localparam int SLOT_W = MEM_AW + 12;

    function automatic logic [MEM_AW-1:0] slotIndex(
        input logic [STREAM_W-1:0]  s,
        input logic [CHANNEL_W-1:0] c);
        slotIndex = {s, c};
    endfunction

    // storage; connection memory keeps contents across reset
    logic [DATA_W-1:0] connMem [STREAMS*CHANNELS];
    logic [7:0]        dataMem [STREAMS*CHANNELS];
    logic [DATA_W-1:0] switch_control;
    logic [DATA_W-1:0] frame_alignment_result;
    logic [DATA_W-1:0] inputOffset [OFFSETS];
    logic [STREAMS-1:0] activeState;

    // address decode
    wire [1:0] space     = hostAddr[SPACE_HI:SPACE_LO];
    wire [3:0] regSel    = hostAddr[REG_SEL_HI:REG_SEL_LO];
    wire [MEM_AW-1:0] memAddr = hostAddr[MEM_AW-1:0];
    // RQ17 data memory read
    wire isData    = (space == SPACE_DATA);
    // RQ18 connection and register spaces
    wire isConn    = (space == SPACE_CONN);
    wire isRegs    = (space == SPACE_REGS);
    // RQ21 low bits ignored
    wire isControl = isRegs && (regSel == SEL_CONTROL);
    wire isAlign   = isRegs && (regSel == SEL_ALIGN);
    wire [3:0] offIdx = regSel - SEL_OFFSET0;
    wire isOffset  = isRegs && (regSel >= SEL_OFFSET0)
                     && (offIdx < 4'(OFFSETS));

    // control fields
    wire standby    = switch_control[CR_STANDBY];
    wire enInd      = switch_control[CR_ENABLE_IND];
    wire allInd     = switch_control[CR_ALL_OUT_IND];
    wire polarity   = switch_control[CR_IND_POLARITY];
    wire [3:0] rate = switch_control[CR_RATE_HI:0];
    // RQ7 all-outputs wins
    wire ind_mode_t indMode = allInd ? IND_ALL :
                              (enInd ? IND_LOWER : IND_NONE);
    // RQ1 pin or standby enables
    wire globalEnable = output_drive_enable_pin || standby;

    // current slot entry
    wire [MEM_AW-1:0] curSlot = slotIndex(slotStream, slotChannel);
    wire [DATA_W-1:0] entry   = connMem[curSlot];
    wire channel_delay_select_t sel =
        channel_delay_select_t'(entry[CM_SEL_HI:CM_SEL_LO]);
    // RQ12 high-z decision
    wire slotDrive = (sel != DELAY_HIGH_Z) && globalEnable;
    // RQ2 processor channel byte
    wire [7:0] slotByte = (sel == DELAY_PROCESSOR) ? entry[7:0]
                                                   : switchedData;
    wire loopHit = entry[CM_LOOPBACK];

    // slot word into fifo
    tsi_slot_if #(.W(SLOT_W)) slotBus ();
    assign slotBus.valid = slotStrobe;
    assign slotBus.data  = {curSlot, slotByte, slotDrive,
                            loopHit, sel};
    logic [SLOT_W-1:0] fifoData;
    logic              fifoValid;
    tsi_fifo #(.W(SLOT_W), .DEPTH(FIFO_DEPTH)) slotFifo (
        .clock    (clock),
        .rstn     (rstn),
        .inPort   (slotBus),
        .outData  (fifoData),
        .outValid (fifoValid),
        .outReady (1'b1)
    );
    wire [MEM_AW-1:0] fSlot  = fifoData[SLOT_W-1:12];
    wire [7:0]        fByte  = fifoData[11:4];
    wire              fDrive = fifoData[3];
    wire              fLoop  = fifoData[2];
    wire [1:0]        fSel   = fifoData[1:0] == 2'h0 ? 2'h0 : fifoData[1:0];
    wire [4:0]        fStream = fSlot[MEM_AW-1:8];

    // pin shaping with indication
    wire [15:0] lowerState = activeState[15:0];
    wire [15:0] indBits    = polarity ? lowerState : ~lowerState;
    logic [STREAMS-1:0] next_txOut;
    logic [STREAMS-1:0] next_txOe;
    always_comb
    begin
        next_txOut = txOut;
        next_txOe  = activeState;
        if (fifoValid)
        begin
            next_txOut[fStream] = fByte[7];
            next_txOe[fStream]  = fDrive;
        end
        case (indMode)
            // RQ19 upper pins indicate
            IND_LOWER:
            begin
                // RQ20 polarity applied
                next_txOut[31:16] = indBits;
                // RQ6 half streams used
                next_txOe[31:16]  = 16'hFFFF;
            end
            IND_ALL:
            begin
                next_txOut = polarity ? next_txOe : ~next_txOe;
                next_txOe  = {STREAMS{1'b1}};
            end
            default:
            begin
            end
        endcase
    end

    // register read mux
    logic [DATA_W-1:0] next_rd;
    always_comb
    begin
        next_rd = 16'h0000;
        if (isData)
            next_rd = {8'h00, dataMem[memAddr]};
        else if (isConn)
            next_rd = connMem[memAddr];
        else if (isControl)
            next_rd = switch_control;
        else if (isAlign)
            next_rd = frame_alignment_result;
        else if (isOffset)
            next_rd = inputOffset[offIdx[2:0]];
    end

    // RQ10 memories not reset
    always_ff @(posedge clock)
    begin
        if (hostWrite && isConn)
            connMem[memAddr] <= hostWrData;
        if (slotStrobe)
            // RQ4 loopback into same slot
            dataMem[curSlot] <= loopHit ? slotByte : rxData;
    end

    // RQ9 registers to defaults
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            switch_control         <= CONTROL_RESET;
            frame_alignment_result <= ALIGN_RESET;
            for (int i = 0; i < OFFSETS; i++)
                inputOffset[i] <= OFFSET_RESET;
        end
        else
        begin
            if (hostWrite && isControl)
                switch_control <= hostWrData;
            if (hostWrite && isOffset)
                inputOffset[offIdx[2:0]] <= hostWrData;
            if (alignDone)
                frame_alignment_result <= {4'h0, alignResult};
        end
    end

    // RQ9 outputs high-z at reset
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            txOut         <= '0;
            txOe          <= '0;
            activeState   <= '0;
            hostRdData    <= 16'h0000;
            txByte        <= 8'h00;
            txSlot        <= '0;
            txValid       <= 1'b0;
            txDelayMode   <= 2'h0;
            loopbackByte  <= 8'h00;
            loopbackValid <= 1'b0;
            softReset     <= 1'b0;
        end
        else
        begin
            txOut <= next_txOut;
            txOe  <= next_txOe;
            // RQ16 active state kept
            if (fifoValid)
                activeState[fStream] <= fDrive;
            hostRdData <= hostRead ? next_rd : hostRdData;
            // RQ3 per-entry mode forwarded
            // RQ13 RQ14 RQ15 core applies limits
            txDelayMode   <= fSel;
            txByte        <= fByte;
            txSlot        <= fSlot;
            txValid       <= fifoValid;
            loopbackByte  <= fByte;
            loopbackValid <= fifoValid && fLoop;
            softReset     <= switch_control[CR_SOFT_RESET];
        end
    end
endmodule

// *** tsi_backplane_model.sv ***
// model: serial backplane side, slot timing and receive bytes
// assumes: bench calls sendSlot; clock shared with the block
`timescale 1ns/1ns
module tsi_backplane_model (
    // clock
    input  wire logic  clock,
    // slot timing and data
    output logic       slotStrobe,
    output logic [4:0] slotStream,
    output logic [7:0] slotChannel,
    output logic [7:0] switchedData,
    output logic [7:0] rxData
);
    initial
    begin
        slotStrobe = 1'b0;
        slotStream = 5'h00;
        slotChannel = 8'h00;
        switchedData = 8'h3C;
        rxData = 8'hC3;
    end
    // one strobe per slot; names turned over outside it
    task automatic sendSlot(input logic [4:0] s, input logic [7:0] c);
        @(posedge clock);
        slotStrobe <= 1'b1;
        slotStream <= s;
        slotChannel <= c;
        switchedData <= ~switchedData;
        rxData <= ~rxData;
        @(posedge clock);
        slotStrobe <= 1'b0;
        slotStream <= ~s;
        slotChannel <= ~c;
    endtask
endmodule

// *** tsi_connection_output_control_sva.sv ***
// checker: port timing of the output control block
// assumes: bound to the top module, one clock domain
`timescale 1ns/1ns
module tsi_connection_output_control_sva
    import tsi_pkg::*;
(
    // clock and reset
    input wire logic                       clock,
    input wire logic                       rstn,
    // host port
    input wire logic [tsi_pkg::ADDR_W-1:0] hostAddr,
    input wire logic                       hostRead,
    input wire logic [tsi_pkg::DATA_W-1:0] hostRdData,
    // slots and pins
    input wire logic                       slotStrobe,
    input wire logic                       output_drive_enable_pin,
    input wire logic [tsi_pkg::STREAMS-1:0] txOe,
    input wire logic [7:0]                 txByte,
    input wire logic [tsi_pkg::MEM_AW-1:0] txSlot,
    input wire logic                       txValid,
    input wire logic [1:0]                 txDelayMode,
    input wire logic [7:0]                 loopbackByte,
    input wire logic                       loopbackValid,
    input wire logic                       softReset
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    wire logic [4:0] slotIdx = txSlot[12:8];
    a_reset_quiet: assert property ($rose(rstn) |-> txOe == '0 && !softReset)
        else $error("outputs driven after reset");
    a_slot_latency: assert property (slotStrobe |-> ##2 txValid)
        else $error("slot output missing");
    a_valid_cause: assert property (txValid |-> $past(slotStrobe, 2))
        else $error("slot output without strobe");
    a_read_hold: assert property (!hostRead |=> $stable(hostRdData))
        else $error("read data moved without read");
    a_unmapped_zero: assert property (hostRead && hostAddr[14:13] == 2'b00 |=> hostRdData == '0)
        else $error("unmapped read not zero");
    a_code_highz: assert property (txValid && txDelayMode == DELAY_HIGH_Z |-> !txOe[slotIdx])
        else $error("high-z code drove pin");
    a_drive_on: assert property (txValid && txDelayMode != DELAY_HIGH_Z && output_drive_enable_pin && $past(output_drive_enable_pin, 2) |-> txOe[slotIdx])
        else $error("enabled channel not driven");
    a_loop_byte: assert property (loopbackValid |-> txValid && loopbackByte == txByte)
        else $error("loopback byte differs");
    a_loop_cause: assert property (loopbackValid |-> $past(slotStrobe, 2))
        else $error("loopback without slot");
    cover property (txValid && txDelayMode == DELAY_PROCESSOR);
    cover property (loopbackValid);
    cover property (hostRead ##1 !hostRead);
endmodule
bind tsi_connection_output_control tsi_connection_output_control_sva
    i_tsi_connection_output_control_sva (.clock, .rstn, .hostAddr,
    .hostRead, .hostRdData, .slotStrobe, .output_drive_enable_pin, .txOe,
    .txByte, .txSlot, .txValid, .txDelayMode, .loopbackByte,
    .loopbackValid, .softReset);

// *** tsi_connection_output_control_bench.sv ***
// bench: host port and slot scenarios for the output control block
// assumes: backplane model supplies slots; checker bound by its file
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin nErrors++; \
    $display("CHECK FAILED at %0t: got %h want %h", $time, g, e); end end
module tsi_connection_output_control_bench;
    import tsi_pkg::*;
    localparam logic [14:0] CTRL = 15'h2000;
    localparam logic [14:0] ALIGN = 15'h2200;
    localparam logic [14:0] OFFS = 15'h2400;
    localparam logic [14:0] CONN = 15'h4205;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [14:0] hostAddr = 15'h0000;
    logic [15:0] hostWrData = 16'h0000;
    logic hostWrite = 1'b0;
    logic hostRead = 1'b0;
    logic output_drive_enable_pin = 1'b0;
    logic [15:0] hostRdData;
    logic slotStrobe, txValid, loopbackValid, softReset;
    logic [4:0] slotStream;
    logic [7:0] slotChannel, switchedData, rxData, txByte, loopbackByte;
    logic [31:0] txOut, txOe;
    logic [12:0] txSlot;
    logic [1:0] txDelayMode;
    int nErrors = 0;
    int checked = 0;
    always #50 clock = ~clock;
    tsi_connection_output_control i_tsi_connection_output_control (
        .clock, .rstn, .hostAddr, .hostWrData, .hostWrite, .hostRead,
        .hostRdData, .slotStrobe, .slotStream, .slotChannel, .switchedData,
        .rxData, .alignResult(12'h000), .alignDone(1'b0),
        .output_drive_enable_pin, .txOut, .txOe, .txByte, .txSlot, .txValid,
        .txDelayMode, .loopbackByte, .loopbackValid, .softReset);
    tsi_backplane_model i_tsi_backplane_model (.clock, .slotStrobe,
        .slotStream, .slotChannel, .switchedData, .rxData);
    task automatic hostWr(input logic [14:0] a, input logic [15:0] d);
        @(posedge clock);
        hostAddr <= a;
        hostWrData <= d;
        hostWrite <= 1'b1;
        @(posedge clock);
        hostWrite <= 1'b0;
    endtask
    task automatic hostRd(input logic [14:0] a, input logic [15:0] e);
        @(posedge clock);
        hostAddr <= a;
        hostRead <= 1'b1;
        @(posedge clock);
        hostRead <= 1'b0;
        #1 `CHK(hostRdData, e)
    endtask
    task automatic slotRun;
        i_tsi_backplane_model.sendSlot(5'd2, 8'd5);
        @(posedge clock);
        #1;
    endtask
    task automatic endSim;
        $display("comparisons %0d mismatches %0d", checked, nErrors);
        if (nErrors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic testReset;
        `CHK(txOe, 32'h0)
        `CHK(softReset, 1'b0)
        hostRd(CTRL, CONTROL_RESET);
        hostRd(ALIGN, ALIGN_RESET);
        hostRd(OFFS, OFFSET_RESET);
        $display("reset test done");
    endtask
    task automatic testRegs;
        for (int k = 0; k < 8; k++)
        begin
            hostWr(OFFS + 15'(k << 9) + 15'h01A5, 16'h1100 + 16'(k));
            hostRd(OFFS + 15'(k << 9), 16'h1100 + 16'(k));
            hostWr(OFFS + 15'(k << 9), 16'h0000);
        end
        hostWr(ALIGN, 16'hFFFF);
        hostRd(ALIGN + 15'h0077, 16'h0000);
        hostRd(15'h0123, 16'h0000);
        hostRd(15'h3400, 16'h0000);
        hostWr(CTRL, 16'h8000);
        @(posedge clock);
        #1 `CHK(softReset, 1'b1)
        hostWr(CTRL, 16'h0000);
        $display("register test done");
    endtask
    task automatic testDrive;
        logic [1:0] code;
        logic exp;
        for (int i = 0; i < 8; i++)
        begin
            code = i[2] ? 2'h3 : {1'b0, i[1]};
            exp = code != 2'h3 && (i[0] || i[1]);
            output_drive_enable_pin <= 1'b0;
            hostWr(CTRL, {10'h000, i[1], 5'h00});
            hostWr(CONN, {code, 14'h0000});
            output_drive_enable_pin <= i[0];
            slotRun();
            `CHK(txOe[2], exp)
            `CHK(txDelayMode, code)
            `CHK(txSlot, 13'h0205)
        end
        $display("drive test done");
    endtask
    task automatic testProc;
        for (int lb = 0; lb < 2; lb++)
        begin
            output_drive_enable_pin <= 1'b0;
            hostWr(CONN, {2'h2, lb[0], 5'h00, 8'hA5});
            hostRd(CONN, {2'h2, lb[0], 5'h00, 8'hA5});
            output_drive_enable_pin <= 1'b1;
            slotRun();
            `CHK(txByte, 8'hA5)
            `CHK(txOut[2], 1'b1)
            `CHK(loopbackValid, lb[0])
            if (lb == 1)
                hostRd(15'h6205, 16'h00A5);
        end
        $display("processor channel test done");
    endtask
    task automatic testInd;
        logic [1:0] code;
        logic pol;
        for (int i = 0; i < 5; i++)
        begin
            code = i[1] ? 2'h3 : 2'h2;
            pol = i[0];
            output_drive_enable_pin <= 1'b0;
            hostWr(CTRL, {2'b01, pol, i[2], 12'h000});
            hostWr(CONN, {code, 6'h00, 8'h25});
            output_drive_enable_pin <= 1'b1;
            slotRun();
            @(posedge clock);
            #1 `CHK(txOut[i[2] ? 2 : 18], pol ~^ (code != 2'h3))
        end
        $display("indication test done");
    endtask
    initial
    begin
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        testReset();
        testRegs();
        testDrive();
        testProc();
        testInd();
        endSim();
    end
    initial
    begin
        #2000000;
        nErrors++;
        endSim();
    end
endmodule
